// *** include/acr_cfg.svh ***
// configuration constants of the adc configuration register bank
// assumes inclusion by bare name from the package and the design modules
// Operation
// - wire-mode bit 0: three-wire shared data pin
// - wire-mode bit 1: dedicated read-out pin
// - decimation enable bit inserts 2x filter
// - response select: low-pass 0, high-pass 1
// - correction loop enable bit, default off
// - four-bit threshold scales over-range trip level
// - over-range flag follows overload by 12 cycles
// - threshold resets to fifteen, serves the one channel
// - restart bit controls correction, resets to one
// - restart high holds offset zero, gain one
// - one write updates whole register at once
// - eight-bit address then sixteen-bit data word
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH
// register offsets
`define ACR_OFS_IFC      7'h00
`define ACR_OFS_CORR     7'h01
`define ACR_OFS_OVR      7'h02
`define ACR_OFS_RESTART  7'h03
`define ACR_OFS_SYNC_LO  7'h0e
`define ACR_OFS_SYNC_REF 7'h0f
`define ACR_OFS_TEMP     7'h2b
`define ACR_OFS_SWRST    7'h2c
`define ACR_OFS_SLEEP    7'h37
`define ACR_OFS_BIAS     7'h38
`define ACR_OFS_DRV      7'h3a
`define ACR_OFS_BUS_EN   7'h66
// reset values
`define ACR_RST_IFC      16'h0000
`define ACR_RST_CORR     16'h0000
`define ACR_RST_OVR      16'h0780
`define ACR_RST_RESTART  16'h4b18
`define ACR_RST_SYNC_LO  16'haaa8
`define ACR_RST_SYNC_REF 16'ha000
`define ACR_RST_SLEEP    16'h0000
`define ACR_RST_BIAS     16'hffef
`define ACR_RST_DRV      16'h0000
`define ACR_RST_BUS_EN   16'h0000
// writable bits; fixed bits keep their reset value
`define ACR_MSK_IFC      16'hd000
`define ACR_MSK_CORR     16'h800a
`define ACR_MSK_OVR      16'h0780
`define ACR_MSK_RESTART  16'h4b18
`define ACR_MSK_SYNC_LO  16'hfffc
`define ACR_MSK_SYNC_REF 16'hf070
`define ACR_MSK_SLEEP    16'hc000
`define ACR_MSK_BIAS     16'hffff
`define ACR_MSK_DRV      16'hffff
`define ACR_MSK_BUS_EN   16'hffff
// software reset key word
`define ACR_SWRST_KEY    16'hd2f0
// field positions
`define ACR_BIT_WIRE4    15
`define ACR_BIT_DECIM    14
`define ACR_BIT_HIPASS   12
`define ACR_BIT_CORR_EN  15
`define ACR_BIT_OFS_BIN  3
`define ACR_BIT_HP_ONE   1
`define ACR_OVR_MSB      10
`define ACR_OVR_LSB      7
`define ACR_BIT_RESTART  14
// transfer shape
`define ACR_ADDR_BITS    5'd8
`define ACR_DATA_BITS    5'd16
`define ACR_OVR_LATENCY  12
`endif

// *** include/acr_pkg.sv ***
// types shared by the register bank modules
// assumes acr_cfg.svh on the include path
package acr_pkg;
    `include "acr_cfg.svh"
    // serial transfer phase
    typedef enum logic [1:0] {
        ph_idle,
        ph_addr,
        ph_data,
        ph_done
    } acr_phase_type;
endpackage : acr_pkg

// *** hw/acr_sync.sv ***
// two flip-flop synchroniser for a group of asynchronous pins
// assumes the inputs are independent levels from outside ref_clk
`timescale 1ns/10ps
module acr_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    import acr_pkg::*;
    // both stages live in one state word
    typedef struct packed {
        logic [WIDTH-1:0] meta;   // first stage, read only by second
        logic [WIDTH-1:0] stable; // second stage
    } acr_sync_state_type;
    acr_sync_state_type st, next_st;

    // shift pins through the two stages
    always_comb begin
        next_st = st;
        if (clk_en) begin
            next_st.meta   = pin_in;
            next_st.stable = st.meta;
        end
    end

    // registers; constant reset only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pin_sync = st.stable;
endmodule : acr_sync

// *** hw/acr_ovr_detect.sv ***
// over-range detector with fixed output latency
// assumes sample magnitude arrives on ref_clk, one sample per enabled cycle
`timescale 1ns/10ps
`include "acr_cfg.svh"
module acr_ovr_detect #(
    parameter int MAG_W   = 11,
    parameter int LATENCY = `ACR_OVR_LATENCY
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic [MAG_W-1:0] sample_mag,
    input  wire logic [3:0]       threshold,
    output logic                  overrange_flag
);
    import acr_pkg::*;
    // delay line of compare results
    typedef struct packed {
        logic [LATENCY-1:0] line;
    } acr_ovr_state_type;
    acr_ovr_state_type st, next_st;
    logic [MAG_W-1:0]   trip_level; // full scale times code over sixteen
    logic               exceed;     // overload seen this cycle

    // trip level is the code in the top four magnitude bits
    assign trip_level = {threshold, {(MAG_W-4){1'b0}}};
    assign exceed     = sample_mag > trip_level;

    // one stage per output clock so the flag lags by the latency
    always_comb begin
        next_st = st;
        if (clk_en) begin
            next_st.line = {st.line[LATENCY-2:0], exceed};
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign overrange_flag = st.line[LATENCY-1];
endmodule : acr_ovr_detect

// *** hw/acr_reg_bank.sv ***
// serial-programmed configuration register bank of a one-channel adc
// assumes serial pins come asynchronously from the host controller and
// that sample magnitude and temperature come from logic on ref_clk
`timescale 1ns/10ps
`include "acr_cfg.svh"
module acr_reg_bank #(
    parameter int MAG_W = 11
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    // serial port pins
    input  wire logic             serial_clk,
    input  wire logic             serial_select_n,
    input  wire logic             sdio_in,
    output logic                  sdio_out,
    output logic                  sdio_oe,
    output logic                  serial_read_out,
    // data path controls
    output logic                  four_wire_mode,
    output logic                  decim_enable,
    output logic                  filter_response_select,
    output logic                  correction_loop_enable,
    output logic                  offset_binary_format,
    output logic                  high_perf_setting_one,
    output logic                  correction_restart,
    output logic                  correction_hold,
    output logic [3:0]            overrange_threshold,
    // raw words of the mapped-only registers
    output logic [15:0]           sync_select_low,
    output logic [15:0]           sync_and_reference_select,
    output logic [15:0]           sleep_mode_select,
    output logic [15:0]           power_and_bias_control,
    output logic [15:0]           output_driver_control,
    output logic [15:0]           output_bus_enable,
    // over-range path
    input  wire logic [MAG_W-1:0] sample_mag,
    output logic                  overrange_flag,
    // temperature sensor value for read-back
    input  wire logic [8:0]       temp_value
);
    import acr_pkg::*;

    // whole state of the serial engine and register file
    typedef struct packed {
        acr_phase_type phase;     // transfer phase
        logic          sclk_prev; // last synchronised serial clock
        logic [4:0]    bit_cnt;   // bits taken in this phase
        logic [15:0]   shift_in;  // incoming bits, msb first
        logic          read_req;  // transfer is a read
        logic [6:0]    addr;      // register address
        logic [15:0]   shift_out; // read data, msb on the pin
        logic          out_act;   // read data being driven
        logic [15:0]   interface_and_filter_control;
        logic [15:0]   correction_and_format_control;
        logic [15:0]   overrange_threshold_control;
        logic [15:0]   correction_restart_control;
        logic [15:0]   sync_select_low;
        logic [15:0]   sync_and_reference_select;
        logic [15:0]   sleep_mode_select;
        logic [15:0]   power_and_bias_control;
        logic [15:0]   output_driver_control;
        logic [15:0]   output_bus_enable;
    } acr_bank_state_type;

    acr_bank_state_type st, next_st;
    logic [2:0]  pins_sync;   // synchronised clock, select, data
    logic        sclk_s;      // serial clock, ref_clk domain
    logic        sel_n_s;     // select, active low, ref_clk domain
    logic        sdi_s;       // serial data in, ref_clk domain
    logic        sclk_rise;   // serial clock rising edge seen
    logic        sclk_fall;   // serial clock falling edge seen
    logic [15:0] rdata;       // read mux output
    logic [15:0] wdata;       // completed write word
    logic [7:0]  addr_word;   // completed address word

    // every serial pin passes two flops before use
    // select enters inverted so cleared stages read as idle after reset
    acr_sync #(
        .WIDTH    (3)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .pin_in   ({serial_clk, ~serial_select_n, sdio_in}),
        .pin_sync (pins_sync)
    );

    assign sclk_s  = pins_sync[2];
    assign sel_n_s = ~pins_sync[1];
    assign sdi_s   = pins_sync[0];

    // edges found from the second stage only
    assign sclk_rise = sclk_s & ~st.sclk_prev;
    assign sclk_fall = ~sclk_s & st.sclk_prev;

    // first bit is read/write, then a6..a0
    assign addr_word = {st.shift_in[6:0], sdi_s};
    // data word closes with the sixteenth data bit
    assign wdata     = {st.shift_in[14:0], sdi_s};

    // read mux; unmapped and write-only addresses read zero
    always_comb begin
        case (st.addr)
            `ACR_OFS_IFC:      rdata = st.interface_and_filter_control;
            `ACR_OFS_CORR:     rdata = st.correction_and_format_control;
            `ACR_OFS_OVR:      rdata = st.overrange_threshold_control;
            `ACR_OFS_RESTART:  rdata = st.correction_restart_control;
            `ACR_OFS_SYNC_LO:  rdata = st.sync_select_low;
            `ACR_OFS_SYNC_REF: rdata = st.sync_and_reference_select;
            `ACR_OFS_TEMP:     rdata = {7'h00, temp_value};
            `ACR_OFS_SLEEP:    rdata = st.sleep_mode_select;
            `ACR_OFS_BIAS:     rdata = st.power_and_bias_control;
            `ACR_OFS_DRV:      rdata = st.output_driver_control;
            `ACR_OFS_BUS_EN:   rdata = st.output_bus_enable;
            default:           rdata = 16'h0000;
        endcase
    end

    // keep fixed bits at reset value, take writable bits from the word
    function automatic logic [15:0] merge(
        input logic [15:0] d,
        input logic [15:0] msk,
        input logic [15:0] dflt
    );
        merge = (d & msk) | (dflt & ~msk);
    endfunction : merge

    // serial engine and register updates
    always_comb begin
        next_st = st;
        if (clk_en) begin
            next_st.sclk_prev = sclk_s;
            case (st.phase)
                // wait for select to fall
                ph_idle: begin
                    if (!sel_n_s) begin
                        next_st.phase   = ph_addr;
                        next_st.bit_cnt = 5'd0;
                        next_st.out_act = 1'b0;
                    end
                end
                // eight address bits on rising edges
                ph_addr: begin
                    if (sclk_rise) begin
                        next_st.shift_in = wdata;
                        next_st.bit_cnt  = st.bit_cnt + 5'd1;
                        if (st.bit_cnt == `ACR_ADDR_BITS - 5'd1) begin
                            next_st.read_req = addr_word[7];
                            next_st.addr     = addr_word[6:0];
                            next_st.phase    = ph_data;
                            next_st.bit_cnt  = 5'd0;
                        end
                    end
                end
                // sixteen data bits in, or read data out
                ph_data: begin
                    if (sclk_rise) begin
                        next_st.shift_in = wdata;
                        next_st.bit_cnt  = st.bit_cnt + 5'd1;
                        if (st.bit_cnt == `ACR_DATA_BITS - 5'd1) begin
                            next_st.phase = ph_done;
                            // a read never writes; all fields land together
                            if (!st.read_req) begin
                                case (st.addr)
                                    `ACR_OFS_IFC: begin
                                        next_st.interface_and_filter_control =
                                            merge(wdata, `ACR_MSK_IFC, `ACR_RST_IFC);
                                    end
                                    `ACR_OFS_CORR: begin
                                        next_st.correction_and_format_control =
                                            merge(wdata, `ACR_MSK_CORR, `ACR_RST_CORR);
                                    end
                                    `ACR_OFS_OVR: begin
                                        next_st.overrange_threshold_control =
                                            merge(wdata, `ACR_MSK_OVR, `ACR_RST_OVR);
                                    end
                                    `ACR_OFS_RESTART: begin
                                        next_st.correction_restart_control =
                                            merge(wdata, `ACR_MSK_RESTART, `ACR_RST_RESTART);
                                    end
                                    `ACR_OFS_SYNC_LO: begin
                                        next_st.sync_select_low =
                                            merge(wdata, `ACR_MSK_SYNC_LO, `ACR_RST_SYNC_LO);
                                    end
                                    `ACR_OFS_SYNC_REF: begin
                                        next_st.sync_and_reference_select =
                                            merge(wdata, `ACR_MSK_SYNC_REF, `ACR_RST_SYNC_REF);
                                    end
                                    `ACR_OFS_SLEEP: begin
                                        next_st.sleep_mode_select =
                                            merge(wdata, `ACR_MSK_SLEEP, `ACR_RST_SLEEP);
                                    end
                                    `ACR_OFS_BIAS: begin
                                        next_st.power_and_bias_control =
                                            merge(wdata, `ACR_MSK_BIAS, `ACR_RST_BIAS);
                                    end
                                    `ACR_OFS_DRV: begin
                                        next_st.output_driver_control =
                                            merge(wdata, `ACR_MSK_DRV, `ACR_RST_DRV);
                                    end
                                    `ACR_OFS_BUS_EN: begin
                                        next_st.output_bus_enable =
                                            merge(wdata, `ACR_MSK_BUS_EN, `ACR_RST_BUS_EN);
                                    end
                                    // key word puts every register back to default
                                    `ACR_OFS_SWRST: begin
                                        if (wdata == `ACR_SWRST_KEY) begin
                                            next_st.interface_and_filter_control  = `ACR_RST_IFC;
                                            next_st.correction_and_format_control = `ACR_RST_CORR;
                                            next_st.overrange_threshold_control   = `ACR_RST_OVR;
                                            next_st.correction_restart_control    = `ACR_RST_RESTART;
                                            next_st.sync_select_low               = `ACR_RST_SYNC_LO;
                                            next_st.sync_and_reference_select     = `ACR_RST_SYNC_REF;
                                            next_st.sleep_mode_select             = `ACR_RST_SLEEP;
                                            next_st.power_and_bias_control        = `ACR_RST_BIAS;
                                            next_st.output_driver_control         = `ACR_RST_DRV;
                                            next_st.output_bus_enable             = `ACR_RST_BUS_EN;
                                        end
                                    end
                                    // temperature is read only, others unmapped
                                    default: begin
                                        next_st.addr = st.addr;
                                    end
                                endcase
                            end
                        end
                    end
                    // first falling edge loads the word, later ones shift it
                    if (sclk_fall && st.read_req) begin
                        if (!st.out_act) begin
                            next_st.shift_out = rdata;
                            next_st.out_act   = 1'b1;
                        end else begin
                            next_st.shift_out = {st.shift_out[14:0], 1'b0};
                        end
                    end
                end
                // word complete; wait for select to rise
                ph_done: begin
                    if (sclk_fall && st.out_act) begin
                        next_st.shift_out = {st.shift_out[14:0], 1'b0};
                    end
                end
                default: begin
                    next_st.phase = ph_idle;
                end
            endcase
            // select rising aborts or ends any transfer
            if (sel_n_s) begin
                next_st.phase   = ph_idle;
                next_st.out_act = 1'b0;
            end
        end
    end

    // state register; every register takes its documented default
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st.phase                         <= ph_idle;
            st.sclk_prev                     <= 1'b0;
            st.bit_cnt                       <= 5'd0;
            st.shift_in                      <= 16'h0000;
            st.read_req                      <= 1'b0;
            st.addr                          <= 7'h00;
            st.shift_out                     <= 16'h0000;
            st.out_act                       <= 1'b0;
            st.interface_and_filter_control  <= `ACR_RST_IFC;
            st.correction_and_format_control <= `ACR_RST_CORR;
            st.overrange_threshold_control   <= `ACR_RST_OVR;
            st.correction_restart_control    <= `ACR_RST_RESTART;
            st.sync_select_low               <= `ACR_RST_SYNC_LO;
            st.sync_and_reference_select     <= `ACR_RST_SYNC_REF;
            st.sleep_mode_select             <= `ACR_RST_SLEEP;
            st.power_and_bias_control        <= `ACR_RST_BIAS;
            st.output_driver_control         <= `ACR_RST_DRV;
            st.output_bus_enable             <= `ACR_RST_BUS_EN;
        end else begin
            st <= next_st;
        end
    end

    // wire mode picks the pin that carries read data
    assign four_wire_mode  = st.interface_and_filter_control[`ACR_BIT_WIRE4];
    // three-wire mode turns the shared pin round during read data
    assign sdio_oe         = st.out_act & ~four_wire_mode;
    assign sdio_out        = st.shift_out[15];
    // four-wire mode keeps the shared pin input-only
    assign serial_read_out = st.shift_out[15] & st.out_act & four_wire_mode;

    // data path control fields
    assign decim_enable           = st.interface_and_filter_control[`ACR_BIT_DECIM];
    // response has no effect unless decimation is on
    assign filter_response_select = st.interface_and_filter_control[`ACR_BIT_HIPASS] & decim_enable;
    assign correction_loop_enable = st.correction_and_format_control[`ACR_BIT_CORR_EN];
    assign offset_binary_format   = st.correction_and_format_control[`ACR_BIT_OFS_BIN];
    assign high_perf_setting_one  = st.correction_and_format_control[`ACR_BIT_HP_ONE];
    assign overrange_threshold    = st.overrange_threshold_control[`ACR_OVR_MSB:`ACR_OVR_LSB];
    assign correction_restart     = st.correction_restart_control[`ACR_BIT_RESTART];
    // restart high or loop disabled forces offset zero and gain one; otherwise the loop runs
    assign correction_hold        = correction_restart | ~correction_loop_enable;

    // raw words of the mapped-only registers
    assign sync_select_low           = st.sync_select_low;
    assign sync_and_reference_select = st.sync_and_reference_select;
    assign sleep_mode_select         = st.sleep_mode_select;
    assign power_and_bias_control    = st.power_and_bias_control;
    assign output_driver_control     = st.output_driver_control;
    assign output_bus_enable         = st.output_bus_enable;

    // one threshold serves the channel's over-range detector
    acr_ovr_detect #(
        .MAG_W          (MAG_W),
        .LATENCY        (`ACR_OVR_LATENCY)
    ) u_ovr (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .clk_en         (clk_en),
        .sample_mag     (sample_mag),
        .threshold      (overrange_threshold),
        .overrange_flag (overrange_flag)
    );
endmodule : acr_reg_bank

// *** tb/acr_reg_bank_asserts.sv ***
// port assertions for the register bank
// assumes clk_en is held high by the bench
`timescale 1ns/10ps
module acr_reg_bank_asserts #(parameter int MAG_W = 11) (
    input wire logic             ref_clk, rst, serial_select_n, sdio_oe, serial_read_out,
    input wire logic             four_wire_mode, decim_enable, filter_response_select,
    input wire logic             correction_loop_enable, correction_restart, correction_hold, overrange_flag,
    input wire logic [3:0]       overrange_threshold,
    input wire logic [MAG_W-1:0] sample_mag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire trip = sample_mag > {overrange_threshold, 7'h00}; // level crossing the threshold
    // select idle long enough for synchronisers and write to settle
    sequence s_idle; serial_select_n [*8]; endsequence
    AST_OE_4W: assert property (four_wire_mode |-> !sdio_oe) else $error("shared pin driven");
    AST_SDO_3W: assert property (!four_wire_mode |-> !serial_read_out) else $error("read-out active");
    AST_OE_IDLE: assert property (s_idle |-> !sdio_oe) else $error("pin driven while idle");
    AST_RESP: assert property (filter_response_select |-> decim_enable) else $error("response w/o filter");
    AST_HOLD: assert property (correction_restart |-> correction_hold) else $error("hold missing");
    AST_RUN: assert property (correction_loop_enable && !correction_restart |-> !correction_hold)
        else $error("loop not running");
    AST_OVR: assert property (1'b1 |-> ##12 (overrange_flag == $past(trip, 12))) else $error("flag latency wrong");
    AST_STABLE: assert property (s_idle |-> $stable({decim_enable, four_wire_mode, overrange_threshold}))
        else $error("control moved while idle");
endmodule : acr_reg_bank_asserts
bind acr_reg_bank acr_reg_bank_asserts #(.MAG_W(MAG_W)) u_chk (.ref_clk, .rst, .serial_select_n, .sdio_oe,
    .serial_read_out, .four_wire_mode, .decim_enable, .filter_response_select, .correction_loop_enable,
    .correction_restart, .correction_hold, .overrange_flag, .overrange_threshold, .sample_mag);

// *** tb/acr_host_model.sv ***
// host controller model driving the serial port
// assumes calls arrive at a falling ref_clk edge; 8 ref_clk per serial bit
`timescale 1ns/10ps
module acr_host_model (
    input wire logic ref_clk, sdio_out, sdio_oe, serial_read_out, four_wire_mode,
    output logic     serial_clk, serial_select_n, sdio_in
);
    logic drv = 1'b1; // host level on the shared pin
    initial begin
        serial_clk = 1'b0;
        serial_select_n = 1'b1;
    end
    // device wins the shared wire while it drives it
    assign sdio_in = sdio_oe ? sdio_out : drv;
    // n bits msb first; clock stands low outside frames; short n aborts
    task automatic xfer(input logic [23:0] w, input int n, output logic [15:0] rq);
        rq = 16'h0000;
        serial_select_n = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            drv = w[i];
            repeat (4) @(negedge ref_clk);
            serial_clk = 1'b1;
            rq = {rq[14:0], four_wire_mode ? serial_read_out : sdio_in};
            repeat (4) @(negedge ref_clk);
            serial_clk = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        serial_select_n = 1'b1;
        drv = ~drv; // released pin shows no stale level
        repeat (6) @(negedge ref_clk);
    endtask : xfer
endmodule : acr_host_model

// *** tb/acr_reg_bank_bench.sv ***
// self-checking bench for the register bank
// assumes the host model owns the serial pins
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module acr_reg_bank_bench;
    logic        ref_clk = 1'b0, rst = 1'b1;
    logic        serial_clk, serial_select_n, sdio_in, sdio_out, sdio_oe, serial_read_out, four_wire_mode;
    logic        decim_enable, filter_response_select, correction_loop_enable, offset_binary_format;
    logic        high_perf_setting_one, correction_restart, correction_hold, overrange_flag;
    logic [3:0]  overrange_threshold;
    logic [10:0] sample_mag = 11'h000;
    logic [15:0] q;
    int          err_count = 0, comparisons = 0, cyc = 0;
    acr_reg_bank dut (.ref_clk, .rst, .clk_en(1'b1), .serial_clk, .serial_select_n, .sdio_in, .sdio_out, .sdio_oe,
        .serial_read_out, .four_wire_mode, .decim_enable, .filter_response_select, .correction_loop_enable,
        .offset_binary_format, .high_perf_setting_one, .correction_restart, .correction_hold, .overrange_threshold,
        .sync_select_low(), .sync_and_reference_select(), .sleep_mode_select(), .power_and_bias_control(),
        .output_driver_control(), .output_bus_enable(), .sample_mag, .overrange_flag, .temp_value(9'h1a5));
    acr_host_model host (.ref_clk, .sdio_out, .sdio_oe, .serial_read_out, .four_wire_mode, .serial_clk,
        .serial_select_n, .sdio_in);
    task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n = 24);
        host.xfer({1'b0, a, d}, n, q);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        host.xfer({1'b1, a, 16'h0000}, 24, q);
        `CHK(q, e)
    endtask : rd
    task automatic wrap_up;
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // hang guard, far above the few thousand cycles the run needs
    always @(posedge ref_clk) if (++cyc == 20000) begin
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        rd(7'h02, 16'h0780);
        rd(7'h03, 16'h4b18);
        `CHK({overrange_threshold, correction_restart, correction_hold}, 6'h3f)
        rd(7'h00, 16'h0000);
        wr(7'h01, 16'h800a);
        `CHK({correction_loop_enable, offset_binary_format, high_perf_setting_one, correction_hold}, 4'hf)
        wr(7'h03, 16'h0b18);
        `CHK({correction_restart, correction_hold}, 2'b00)
        wr(7'h00, 16'hc000, 20); // select rises mid-word
        `CHK({four_wire_mode, decim_enable}, 2'b00)
        wr(7'h00, 16'hd000); // fixed bits written as zero
        `CHK({four_wire_mode, decim_enable, filter_response_select}, 3'h7)
        rd(7'h00, 16'hd000);
        rd(7'h01, 16'h800a);
        wr(7'h2b, 16'h01ff); // read-only place
        rd(7'h2b, 16'h01a5);
        rd(7'h10, 16'h0000);
        wr(7'h02, 16'h0180);
        `CHK(overrange_threshold, 4'h3)
        sample_mag = 11'h180;
        @(negedge ref_clk);
        sample_mag = 11'h181;
        @(negedge ref_clk);
        sample_mag = 11'h000;
        repeat (10) @(negedge ref_clk);
        `CHK(overrange_flag, 1'b0)
        @(negedge ref_clk);
        `CHK(overrange_flag, 1'b1)
        wr(7'h2c, 16'hd2f0); // software reset key
        rd(7'h02, 16'h0780);
        wrap_up();
    end
endmodule : acr_reg_bank_bench
